// ---- rtl/adcrr_pkg.sv ----
// constants shared by the conversion result register pair
package adcrr_pkg;

  localparam int unsigned ADCRR_RES_W = 10;
  localparam int unsigned ADCRR_ADDR_W = 3;
  localparam int unsigned ADCRR_DATA_W = 8;
  localparam int unsigned ADCRR_MUX_W = 5;

  // register offsets on the plain register port
  localparam logic [ADCRR_ADDR_W-1:0] ADCRR_OFS_LOW = 3'h0;
  localparam logic [ADCRR_ADDR_W-1:0] ADCRR_OFS_HIGH = 3'h1;
  localparam logic [ADCRR_ADDR_W-1:0] ADCRR_OFS_MUX = 3'h2;
  localparam logic [ADCRR_ADDR_W-1:0] ADCRR_OFS_STATUS = 3'h3;
  localparam logic [ADCRR_ADDR_W-1:0] ADCRR_OFS_MASK = 3'h4;

  // channel mux register fields
  localparam int unsigned ADCRR_MUX_LADJ_BIT = 5;
  localparam int unsigned ADCRR_MUX_SEL_LSB = 0;
  localparam logic [ADCRR_DATA_W-1:0] ADCRR_MUX_WMASK = 8'h3F;

  // status / mask fields
  localparam int unsigned ADCRR_ST_DONE_BIT = 0;
  localparam int unsigned ADCRR_ST_DROP_BIT = 1;
  localparam int unsigned ADCRR_ST_W = 2;
  localparam logic [ADCRR_ST_W-1:0] ADCRR_ST_RESET = 2'h0;

  // single-ended codes: 00000..00111 and 11110..11111
  localparam logic [ADCRR_MUX_W-1:0] ADCRR_SE_LAST = 5'h07;
  localparam logic [ADCRR_MUX_W-1:0] ADCRR_SE_HI_FIRST = 5'h1E;

  localparam logic [ADCRR_RES_W-1:0] ADCRR_RES_RESET = 10'h000;
  localparam logic [ADCRR_DATA_W-1:0] ADCRR_BYTE_ZERO = 8'h00;

endpackage

// ---- rtl/adcrr_format.sv ----
// combinational placement of the stored result into the byte pair
`timescale 1ns/1ps
`default_nettype none
module adcrr_format
  import adcrr_pkg::*;
(
  // stored word and layout choice
  input wire logic [ADCRR_RES_W-1:0] stored,
  input wire logic left_adjust_select,
  // presented bytes
  output logic [ADCRR_DATA_W-1:0] pres_high,
  output logic [ADCRR_DATA_W-1:0] pres_low
);

  // purely combinational so a select change shows at once
  always_comb
  begin
    if (left_adjust_select)
    begin
      pres_high = stored[9:2];
      pres_low = {stored[1:0], 6'h00};
    end
    else
    begin
      pres_high = {6'h00, stored[9:8]};
      pres_low = stored[7:0];
    end
  end

endmodule
`default_nettype wire

// ---- rtl/adcrr_encode.sv ----
// converts a raw converter word to the stored encoding
`timescale 1ns/1ps
`default_nettype none
module adcrr_encode
  import adcrr_pkg::*;
(
  // raw sample and channel choice
  input wire logic [ADCRR_RES_W-1:0] raw,
  input wire logic [ADCRR_MUX_W-1:0] channel_select_bits,
  // encoded word
  output logic [ADCRR_RES_W-1:0] coded,
  output logic differential
);

  // the channel code alone decides signed or unsigned
  function automatic logic is_diff(input logic [ADCRR_MUX_W-1:0] sel);
    is_diff = (sel > ADCRR_SE_LAST) && (sel < ADCRR_SE_HI_FIRST);
  endfunction

  // raw is offset binary from the converter; flipping the msb gives
  // two's complement, which avoids a subtractor
  always_comb
  begin
    differential = is_diff(channel_select_bits);
    coded = raw;
    if (differential)
    begin
      coded = {~raw[ADCRR_RES_W-1], raw[ADCRR_RES_W-2:0]};
    end
  end

endmodule
`default_nettype wire

// ---- rtl/adcrr_top.sv ----
// conversion result register pair with update lock and event flags
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module adcrr_top
  import adcrr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [ADCRR_ADDR_W-1:0] reg_addr,
  input wire logic [ADCRR_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ADCRR_DATA_W-1:0] reg_rdata,
  // converter side, same clock
  input wire logic conv_done,
  input wire logic [ADCRR_RES_W-1:0] conv_raw,
  // status outputs
  output logic conversion_complete_flag,
  output logic result_locked,
  output logic irq
);

  typedef struct packed {
    logic [ADCRR_RES_W-1:0] stored;
    logic locked;
    logic [ADCRR_DATA_W-1:0] channel_mux_register;
    logic [ADCRR_ST_W-1:0] status;
    logic [ADCRR_ST_W-1:0] mask;
    logic [ADCRR_DATA_W-1:0] rdata;
    logic irq;
  } adcrr_state_t;

  adcrr_state_t st;
  adcrr_state_t next_st;

  logic [ADCRR_RES_W-1:0] coded;
  logic [ADCRR_DATA_W-1:0] result_high_byte;
  logic [ADCRR_DATA_W-1:0] result_low_byte;
  logic left_adjust_select;
  logic [ADCRR_MUX_W-1:0] channel_select_bits;

  assign left_adjust_select = st.channel_mux_register[ADCRR_MUX_LADJ_BIT];
  assign channel_select_bits =
    st.channel_mux_register[ADCRR_MUX_SEL_LSB +: ADCRR_MUX_W];

  // encoding follows the live channel selection
  adcrr_encode u_encode (
    .raw(conv_raw),
    .channel_select_bits(channel_select_bits),
    .coded(coded),
    .differential()
  );

  // layout follows the live left-adjust select
  adcrr_format u_format (
    .stored(st.stored),
    .left_adjust_select(left_adjust_select),
    .pres_high(result_high_byte),
    .pres_low(result_low_byte)
  );

  // next-state logic for the whole block
  always_comb
  begin
    logic rd_low;
    logic rd_high;
    logic rd_status;
    logic accept;
    logic [ADCRR_ST_W-1:0] ev;
    rd_low = 1'b0;
    rd_high = 1'b0;
    rd_status = 1'b0;
    accept = 1'b0;
    ev = ADCRR_ST_RESET;
    next_st = st;
    rd_low = reg_rd && (reg_addr == ADCRR_OFS_LOW);
    rd_high = reg_rd && (reg_addr == ADCRR_OFS_HIGH);
    rd_status = reg_rd && (reg_addr == ADCRR_OFS_STATUS);

    // a result is dropped while software holds the pair
    accept = conv_done && !st.locked;
    if (accept)
    begin
      next_st.stored = coded;
    end
    ev[ADCRR_ST_DONE_BIT] = accept;
    ev[ADCRR_ST_DROP_BIT] = conv_done && st.locked;

    // low read locks, high read unlocks; a high-only read never locks
    if (rd_high)
    begin
      next_st.locked = 1'b0;
    end
    else if (rd_low)
    begin
      next_st.locked = 1'b1;
    end

    // read data; bytes have no write path so writes there are ignored
    next_st.rdata = ADCRR_BYTE_ZERO;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADCRR_OFS_LOW: next_st.rdata = result_low_byte;
        ADCRR_OFS_HIGH: next_st.rdata = result_high_byte;
        ADCRR_OFS_MUX: next_st.rdata = st.channel_mux_register;
        ADCRR_OFS_STATUS: next_st.rdata = {6'h00, st.status};
        ADCRR_OFS_MASK: next_st.rdata = {6'h00, st.mask};
        default: next_st.rdata = ADCRR_BYTE_ZERO;
      endcase
    end

    // control writes
    if (reg_wr && reg_addr == ADCRR_OFS_MUX)
    begin
      next_st.channel_mux_register = reg_wdata & ADCRR_MUX_WMASK;
    end
    if (reg_wr && reg_addr == ADCRR_OFS_MASK)
    begin
      next_st.mask = reg_wdata[ADCRR_ST_W-1:0];
    end

    // sticky flags cleared by read; a same-cycle event still sets
    if (rd_status)
    begin
      next_st.status = ev;
    end
    else
    begin
      next_st.status = st.status | ev;
    end
    next_st.irq = |(next_st.status & next_st.mask);
  end

  // single state register; everything resets to zero
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign reg_rdata = st.rdata;
  assign conversion_complete_flag = st.status[ADCRR_ST_DONE_BIT];
  assign result_locked = st.locked;
  assign irq = st.irq;

endmodule
`default_nettype wire

// ---- verification/adcrr_checker.sv ----
// port-level assertions for the result register pair
`timescale 1ns/1ps
`default_nettype none
module adcrr_checker
  import adcrr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [ADCRR_ADDR_W-1:0] reg_addr,
  input wire logic [ADCRR_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADCRR_DATA_W-1:0] reg_rdata,
  // converter side and status
  input wire logic conv_done,
  input wire logic [ADCRR_RES_W-1:0] conv_raw,
  input wire logic conversion_complete_flag,
  input wire logic result_locked,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // read data only stand in the cycle after a read strobe
  property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
  property p_unmap; reg_rd && reg_addr > ADCRR_OFS_MASK |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  // the lock follows the low and high byte reads
  property p_lock; reg_rd && reg_addr == ADCRR_OFS_LOW |=> result_locked;
  endproperty
  a_lock: assert property (p_lock) else $error("low read no lock");
  property p_unlock; reg_rd && reg_addr == ADCRR_OFS_HIGH |=> !result_locked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("high read no unlock");
  property p_hold;
    result_locked && !(reg_rd && reg_addr == ADCRR_OFS_HIGH) |=> result_locked;
  endproperty
  a_hold: assert property (p_hold) else $error("lock lost early");
  // the done flag rises from an accepted conversion and never rises without conv_done
  property p_done; conv_done && !result_locked |=> conversion_complete_flag;
  endproperty
  a_done: assert property (p_done) else $error("done flag missing");
  property p_nodone;
    !conv_done && !conversion_complete_flag |=> !conversion_complete_flag;
  endproperty
  a_nodone: assert property (p_nodone) else $error("spurious done");
  property p_mux; reg_rd && reg_addr == ADCRR_OFS_MUX |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_mux: assert property (p_mux) else $error("mux spare bits set");
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the result register pair
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adcrr_pkg::*;
  logic core_clk = 0;
  logic sys_rst = 1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic conv_done = 0;
  logic [9:0] conv_raw = 10'h000;
  logic [7:0] reg_rdata;
  logic conversion_complete_flag;
  logic result_locked;
  logic irq;
  int failures = 0;
  int checked = 0;
  integer seed = 87;
  logic [7:0] d;
  logic [15:0] exp;
  logic [9:0] raw;
  logic [5:0] mux;
  adcrr_top adcrr_top_inst (.core_clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .conv_done, .conv_raw,
    .conversion_complete_flag, .result_locked, .irq);
  // 100 ns clock
  always #50 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 0;
    // let the flops settle before anyone looks at the outputs
    #1;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  // raw lines carry junk outside the strobe, so a late capture shows up
  task automatic cv(input logic [9:0] r);
    @(posedge core_clk);
    conv_done <= 1;
    conv_raw <= r;
    @(posedge core_clk);
    conv_done <= 0;
    conv_raw <= ~r;
    // flag and irq are launched by this edge, so look a little later
    #1;
  endtask
  // expected byte pair: differential codes flip the msb, bit5 picks layout
  function automatic logic [15:0] fmt(logic [9:0] r, logic [5:0] m);
    logic [9:0] c;
    c = r ^ {(m[4:0] > 5'h07 && m[4:0] < 5'h1E), 9'h000};
    return m[5] ? {c, 6'h00} : {6'h00, c};
  endfunction
  task automatic close_out;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (100000) @(posedge core_clk);
    failures++;
    close_out;
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 0;
    rd(ADCRR_OFS_LOW);
    chk("low", d, 8'h00);
    rd(ADCRR_OFS_HIGH);
    chk("high", d, 8'h00);
    rd(ADCRR_OFS_MUX);
    chk("mux", d, 8'h00);
    // every channel code in both layouts, locked drop each time
    for (int i = 0; i < 64; i++)
    begin
      mux = i[5:0];
      raw = 10'($random(seed));
      // spare mux bits written as junk must read back as zero
      wr(ADCRR_OFS_MUX, {i[1:0], mux});
      rd(ADCRR_OFS_MUX);
      chk("mux", d, {2'b00, mux});
      wr(ADCRR_OFS_MASK, {7'h00, i[0]});
      chk("irq", {7'h00, irq}, 8'h00);
      cv(raw);
      chk("flag", {7'h00, conversion_complete_flag}, 8'h01);
      chk("irq", {7'h00, irq}, {7'h00, i[0]});
      exp = fmt(raw, mux);
      wr(ADCRR_OFS_LOW, 8'hFF);
      rd(ADCRR_OFS_LOW);
      chk("low", d, exp[7:0]);
      mux[5] = ~mux[5];
      wr(ADCRR_OFS_MUX, {2'b00, mux});
      cv(~raw);
      exp = fmt(raw, mux);
      rd(ADCRR_OFS_HIGH);
      chk("high", d, exp[15:8]);
      rd(ADCRR_OFS_STATUS);
      chk("status", d, 8'h03);
    end
    // high-only reads never lock
    wr(ADCRR_OFS_MUX, 8'h20);
    raw = 10'($random(seed));
    cv(raw);
    rd(ADCRR_OFS_HIGH);
    exp = fmt(raw, 6'h20);
    chk("high", d, exp[15:8]);
    chk("locked", {7'h00, result_locked}, 8'h00);
    cv(~raw);
    rd(ADCRR_OFS_HIGH);
    exp = fmt(~raw, 6'h20);
    chk("high", d, exp[15:8]);
    rd(3'h7);
    chk("unmapped", d, 8'h00);
    // a reset in the middle of a locked pair must clear data and lock
    rd(ADCRR_OFS_LOW);
    chk("locked", {7'h00, result_locked}, 8'h01);
    @(posedge core_clk);
    sys_rst <= 1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 0;
    #1;
    chk("locked", {7'h00, result_locked}, 8'h00);
    rd(ADCRR_OFS_HIGH);
    chk("high", d, 8'h00);
    rd(ADCRR_OFS_MUX);
    chk("mux", d, 8'h00);
    close_out;
  end
endmodule
bind adcrr_top adcrr_checker adcrr_checker_inst (.core_clk, .sys_rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .conv_done, .conv_raw,
  .conversion_complete_flag, .result_locked, .irq);
`default_nettype wire
